// [hdl/swsg_top.sv]
// sleep entry, gating sequence and wake source gating for the low-power core
`timescale 1ns/1ps
`include "swsg_defines.svh"
module swsg_top #(
  parameter int LOCK_W = 8,
  parameter int OSC_CYC = `SWSG_OSC_START_US * `SWSG_CLK_MHZ,
  parameter int CRIT_CYC = `SWSG_CRIT_CODE_US * `SWSG_CLK_MHZ,
  parameter int IRQ_CYC = `SWSG_IRQ_ENTRY_US * `SWSG_CLK_MHZ,
  parameter int BCN_CYC = `SWSG_BEACON_MS * 1000 * `SWSG_CLK_MHZ
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // wake source enables and events
  input wire logic [`SWSG_MAIN_W-1:0] main_wake_en_in,
  input wire logic [`SWSG_MAIN_W-1:0] hp_wake_sel_in,
  input wire logic [`SWSG_MAIN_W-1:0] main_evt_in,
  input wire logic aon_en_wr_in,
  input wire logic [`SWSG_AON_W-1:0] aon_en_data_in,
  input wire logic [`SWSG_AON_W-1:0] aon_evt_in,
  // power and wireless modes
  input wire logic deep_lps_in,
  input wire logic deep_sleep_in,
  input wire logic wireless_wake_sleep_in,
  input wire logic assoc_ps_in,
  input wire logic idle_radio_off_in,
  input wire logic beacon_window_in,
  input wire logic tim_pending_in,
  // wakelocks and inter-core message
  input wire logic [LOCK_W-1:0] lock_set_in,
  input wire logic [LOCK_W-1:0] lock_clr_in,
  input wire logic hp_sleep_ipc_in,
  input wire logic hp_pg_sel_in,
  // status and power controls
  output logic [`SWSG_AON_W-1:0] aon_wake_en_out,
  output logic [LOCK_W-1:0] wakelock_out,
  output logic [`SWSG_MAIN_W-1:0] wake_src_out,
  output swsg_pkg::swsg_state_type seq_state_out,
  output logic lp_clk_gated_out,
  output logic hp_clk_gated_out,
  output logic hp_pwr_gated_out,
  output logic hp_reinit_out,
  output logic lp_irq_out,
  output logic radio_on_out
);
  import swsg_pkg::*;

  typedef struct packed {
    swsg_state_type st;
    logic [`SWSG_AON_W-1:0] aon_en;
    logic [LOCK_W-1:0] lock;
    logic [`SWSG_MAIN_W-1:0] src;
    logic [21:0] cnt;
    logic [21:0] bcn;
    logic hp_asleep;
    logic hp_pg;
    logic hp_wake;
    logic lp_gated;
    logic hp_gated;
    logic hp_pwr;
    logic reinit;
    logic irq;
    logic radio;
  } swsg_regs_type;

  swsg_regs_type r;
  swsg_regs_type next_r;

  function automatic logic [21:0] swsg_load(input int cyc);
    swsg_load = 22'(cyc - 1);
  endfunction

  logic [`SWSG_AON_W-1:0] aon_hits;
  logic aon_hit;
  logic [`SWSG_MAIN_W-1:0] main_hits;
  logic beacon_tick;
  logic wake_any;

  always_comb begin
    // beacon sub-source only counts in deep low-power wireless mode
    aon_hits = aon_evt_in & r.aon_en & `SWSG_AON_VALID;
    aon_hits[`SWSG_AON_BEACON] = aon_hits[`SWSG_AON_BEACON] & deep_lps_in;
    aon_hit = (|aon_hits) & main_wake_en_in[`SWSG_EVT_AON];
    main_hits = main_evt_in & main_wake_en_in;
    main_hits[`SWSG_EVT_AON] = aon_hit;
    // deep sleep keeps only the always-on domain powered
    if (deep_sleep_in) begin
      main_hits = '0;
      main_hits[`SWSG_EVT_AON] = aon_hit;
    end
    beacon_tick = wireless_wake_sleep_in && r.hp_asleep && (r.bcn == swsg_load(BCN_CYC));
    wake_any = (|main_hits) || beacon_tick;
  end

  always_comb begin
    next_r = r;
    next_r.irq = 1'b0;
    next_r.reinit = 1'b0;
    if (aon_en_wr_in) begin
      next_r.aon_en = aon_en_data_in & `SWSG_AON_VALID;
    end
    // a set arriving with a clear wins so no acquire is lost
    next_r.lock = (r.lock & ~lock_clr_in) | lock_set_in;
    if (wireless_wake_sleep_in && r.hp_asleep && !beacon_tick) begin
      next_r.bcn = r.bcn + 22'h000001;
    end else begin
      next_r.bcn = '0;
    end
    // radio follows beacon window and traffic flag in power save
    if (assoc_ps_in) begin
      next_r.radio = beacon_window_in | tim_pending_in;
    end else begin
      next_r.radio = !idle_radio_off_in;
    end
    case (r.st)
      SWSG_RUN: begin
        if (hp_sleep_ipc_in && !r.hp_asleep) begin
          next_r.st = SWSG_HP_GATE;
        end else if (r.hp_asleep && r.lock == '0 && lock_set_in == '0) begin
          next_r.st = SWSG_LP_SLEEP;
          next_r.lp_gated = 1'b1;
        end
      end
      SWSG_HP_GATE: begin
        next_r.hp_asleep = 1'b1;
        next_r.hp_gated = 1'b1;
        next_r.hp_pwr = hp_pg_sel_in;
        next_r.hp_pg = hp_pg_sel_in;
        next_r.st = SWSG_LOCK_REL;
      end
      SWSG_LOCK_REL: begin
        next_r.lock[`SWSG_LOCK_LP_OS] = lock_set_in[`SWSG_LOCK_LP_OS];
        next_r.lock[`SWSG_LOCK_HP_RUN] = lock_set_in[`SWSG_LOCK_HP_RUN];
        next_r.st = SWSG_RUN;
      end
      SWSG_LP_SLEEP: begin
        if (wake_any) begin
          next_r.lp_gated = 1'b0;
          next_r.src = main_hits;
          next_r.hp_wake = |(main_hits & hp_wake_sel_in);
          next_r.cnt = swsg_load(OSC_CYC);
          next_r.st = SWSG_OSC;
        end
      end
      SWSG_OSC: begin
        next_r.cnt = r.cnt - 22'h000001;
        if (r.cnt == '0) begin
          next_r.cnt = swsg_load(CRIT_CYC);
          next_r.st = SWSG_CRIT;
        end
      end
      SWSG_CRIT: begin
        next_r.cnt = r.cnt - 22'h000001;
        if (r.cnt == '0) begin
          next_r.cnt = swsg_load(IRQ_CYC);
          next_r.st = SWSG_IRQ;
        end
      end
      SWSG_IRQ: begin
        next_r.cnt = r.cnt - 22'h000001;
        if (r.cnt == '0) begin
          next_r.irq = 1'b1;
          next_r.st = SWSG_RUN;
          // waking the high-perf core takes back its running locks
          if (r.hp_wake) begin
            next_r.hp_asleep = 1'b0;
            next_r.hp_gated = 1'b0;
            next_r.hp_pwr = 1'b0;
            next_r.reinit = r.hp_pg;
            next_r.lock[`SWSG_LOCK_HP_RUN] = 1'b1;
            next_r.lock[`SWSG_LOCK_HP_OS] = 1'b1;
          end
        end
      end
      default: begin
        next_r.st = SWSG_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      r <= '0;
      r.st <= SWSG_RUN;
      r.aon_en <= `SWSG_AON_RST;
      r.lock <= LOCK_W'(`SWSG_LOCK_BOOT);
      r.radio <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign aon_wake_en_out = r.aon_en;
  assign wakelock_out = r.lock;
  assign wake_src_out = r.src;
  assign seq_state_out = r.st;
  assign lp_clk_gated_out = r.lp_gated;
  assign hp_clk_gated_out = r.hp_gated;
  assign hp_pwr_gated_out = r.hp_pwr;
  assign hp_reinit_out = r.reinit;
  assign lp_irq_out = r.irq;
  assign radio_on_out = r.radio;

  // checks; latency helper counts cycles since clocks restarted
  logic [23:0] lat_cnt;
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || r.st == SWSG_LP_SLEEP) begin
      lat_cnt <= '0;
    end else if (lat_cnt != 24'hFFFFFF) begin
      lat_cnt <= lat_cnt + 24'h000001;
    end
  end

  sequence s_hp_ipc;
    r.st == SWSG_RUN && hp_sleep_ipc_in && !r.hp_asleep;
  endsequence
  sequence s_gate_then_release;
    r.st == SWSG_HP_GATE ##1 hp_clk_gated_out && r.st == SWSG_LOCK_REL
      ##1 !wakelock_out[`SWSG_LOCK_LP_OS] || $past(lock_set_in[`SWSG_LOCK_LP_OS]);
  endsequence

  a_main_mask_gate: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    r.st == SWSG_LP_SLEEP && wake_any && !beacon_tick |->
      ((main_evt_in & main_wake_en_in) != '0) || aon_hit)
    else $error("wake taken from a disabled main source");
  a_aon_master: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    aon_hit |-> main_wake_en_in[`SWSG_EVT_AON] && (aon_evt_in & r.aon_en) != '0)
    else $error("always-on wake without master enable");
  a_aon_reset_zero: assert property (@(posedge mclk_in)
    sys_rst_in |=> aon_wake_en_out == `SWSG_AON_RST)
    else $error("always-on enables not zero after reset");
  a_beacon_mode: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    aon_hits[`SWSG_AON_BEACON] |-> deep_lps_in)
    else $error("beacon sub-source passed outside deep low-power mode");
  a_lock_blocks_sleep: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    $rose(lp_clk_gated_out) |-> $past(wakelock_out) == '0)
    else $error("sleep entered with a wakelock held");
  a_boot_locks: assert property (@(posedge mclk_in)
    sys_rst_in |=> wakelock_out == LOCK_W'(`SWSG_LOCK_BOOT))
    else $error("boot wakelocks not held");
  a_sleep_order: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    s_hp_ipc |=> s_gate_then_release)
    else $error("sleep sequence out of order");
  a_wake_latency: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    lp_irq_out |-> lat_cnt == 24'(OSC_CYC + CRIT_CYC + IRQ_CYC))
    else $error("wake latency differs from expected count");
  a_reinit_after_pg: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    hp_reinit_out |-> lp_irq_out && $past(hp_pwr_gated_out))
    else $error("reinit without prior power gating");
  a_wake_restarts: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    r.st == SWSG_LP_SLEEP && wake_any |=> !lp_clk_gated_out && r.st == SWSG_OSC)
    else $error("wake request did not restart clocks");
endmodule

// [shared/swsg_defines.svh]
// constants for the sleep and wake source gating block
// Notes on behaviour
// - each main wake enable bit passes its event when 1, blocks it when 0
// - always-on master enable gates every always-on sub-source
// - always-on sub-enables are read/write, reset 0, at bits 7,6,4,3,2,1,0
// - beacon-timer sub-source wakes only while deep low-power wireless mode is on
// - every enabled source wakes the low-power core; high-perf core wake is selectable (deep sleep masks all main sources except always-on)
// - low-power core clock-gates; high-perf core sleep selects clock or power gating
// - sleep entry refused while any wakelock bitmap bit is set
// - at boot both os locks and the app-core-running lock are held
// - high-perf sleeps, signals, gets gated, low-power locks drop, low-power gates
// - after a wake the system sleeps again promptly unless a lock is taken
// - after power gating, high-perf peripherals must be reinitialised on wake
// - wake latency from oscillator start, critical code and interrupt entry
// - in wireless wake sleep a 102 ms timer wakes the low-power core
// - in associated power save the radio follows beacon timing and traffic flag
// - always-on sources wake from both ordinary sleep and deep sleep
`ifndef SWSG_DEFINES_SVH
`define SWSG_DEFINES_SVH
`define SWSG_MAIN_W 12
`define SWSG_AON_W 8
`define SWSG_EVT_HS_UART 0
`define SWSG_EVT_AON 1
`define SWSG_EVT_SGPIO 2
`define SWSG_EVT_COMP 3
`define SWSG_EVT_ADC 4
`define SWSG_EVT_I2C 5
`define SWSG_EVT_UART 6
`define SWSG_EVT_BROWNOUT 7
`define SWSG_EVT_WIRELESS 8
`define SWSG_EVT_GPIO 9
`define SWSG_EVT_OCP 10
`define SWSG_EVT_TIMER 11
`define SWSG_AON_PDN 7
`define SWSG_AON_TOUCH 6
`define SWSG_AON_KEYSCAN 4
`define SWSG_AON_BEACON 3
`define SWSG_AON_RTC 2
`define SWSG_AON_TIMER 1
`define SWSG_AON_PIN 0
`define SWSG_AON_VALID 8'hDF
`define SWSG_AON_RST 8'h00
`define SWSG_LOCK_LP_OS 0
`define SWSG_LOCK_HP_RUN 1
`define SWSG_LOCK_HP_OS 2
`define SWSG_LOCK_BOOT 8'h07
`define SWSG_CLK_MHZ 25
`define SWSG_OSC_START_US 1600
`define SWSG_CRIT_CODE_US 1100
`define SWSG_IRQ_ENTRY_US 200
`define SWSG_BEACON_MS 102
`endif

// [shared/swsg_pkg.sv]
// types for the sleep and wake source gating block
package swsg_pkg;
  typedef enum logic [2:0] {
    SWSG_RUN,
    SWSG_HP_GATE,
    SWSG_LOCK_REL,
    SWSG_LP_SLEEP,
    SWSG_OSC,
    SWSG_CRIT,
    SWSG_IRQ
  } swsg_state_type;
endpackage

// [tb/swsg_src_model.sv]
// partner model: wake event sources and the application core
`timescale 1ns/1ps
`include "swsg_defines.svh"
module swsg_src_model (
  // clock
  input wire logic mclk_in,
  // toward the block
  output logic [`SWSG_MAIN_W-1:0] main_evt_out,
  output logic [`SWSG_AON_W-1:0] aon_evt_out,
  output logic hp_sleep_ipc_out
);
  initial begin
    main_evt_out = 12'h000;
    aon_evt_out = 8'h00;
    hp_sleep_ipc_out = 1'b0;
  end
  // one-cycle events: the block samples every edge, so a short source is the hard case
  task automatic fire(input logic [11:0] m, input logic [7:0] a);
    @(posedge mclk_in);
    main_evt_out <= m;
    aon_evt_out <= a;
    @(posedge mclk_in);
    main_evt_out <= 12'h000;
    aon_evt_out <= 8'h00;
  endtask
  // app core has slept and says so, only called while it is awake
  task automatic ipc();
    @(posedge mclk_in);
    hp_sleep_ipc_out <= 1'b1;
    @(posedge mclk_in);
    hp_sleep_ipc_out <= 1'b0;
  endtask
endmodule

// [tb/tb_swsg_top.sv]
// self-checking bench for the sleep and wake source gating block
`timescale 1ns/1ps
module tb_swsg_top;
  import swsg_pkg::*;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [11:0] main_wake_en_in = 12'h000;
  logic [11:0] hp_wake_sel_in = 12'h000;
  logic aon_en_wr_in = 1'b0;
  logic [7:0] aon_en_data_in = 8'h00;
  logic deep_lps_in = 1'b0;
  logic deep_sleep_in = 1'b0;
  logic assoc_ps_in = 1'b0;
  logic beacon_window_in = 1'b0;
  logic wireless_wake_sleep_in = 1'b0;
  logic idle_radio_off_in = 1'b0;
  logic tim_pending_in = 1'b0;
  logic hp_pg_sel_in = 1'b0;
  logic [7:0] lock_set_in = 8'h00;
  logic [7:0] lock_clr_in = 8'h00;
  logic [11:0] main_evt;
  logic [7:0] aon_evt;
  logic ipc;
  logic [7:0] aon_wake_en_out;
  logic [7:0] wakelock_out;
  logic [11:0] wake_src_out;
  swsg_state_type seq_state_out;
  logic lp_clk_gated_out;
  logic hp_clk_gated_out;
  logic hp_pwr_gated_out;
  logic hp_reinit_out;
  logic lp_irq_out;
  logic radio_on_out;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  always #20 mclk_in = ~mclk_in;
  // short latencies keep each wake near a dozen cycles
  swsg_top #(.OSC_CYC(5), .CRIT_CYC(4), .IRQ_CYC(3), .BCN_CYC(20)) u_swsg_top (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .main_wake_en_in(main_wake_en_in),
    .hp_wake_sel_in(hp_wake_sel_in), .main_evt_in(main_evt), .aon_en_wr_in(aon_en_wr_in),
    .aon_en_data_in(aon_en_data_in), .aon_evt_in(aon_evt), .deep_lps_in(deep_lps_in),
    .deep_sleep_in(deep_sleep_in), .wireless_wake_sleep_in(wireless_wake_sleep_in),
    .assoc_ps_in(assoc_ps_in), .idle_radio_off_in(idle_radio_off_in),
    .beacon_window_in(beacon_window_in), .tim_pending_in(tim_pending_in),
    .lock_set_in(lock_set_in), .lock_clr_in(lock_clr_in), .hp_sleep_ipc_in(ipc),
    .hp_pg_sel_in(hp_pg_sel_in), .aon_wake_en_out(aon_wake_en_out),
    .wakelock_out(wakelock_out), .wake_src_out(wake_src_out), .seq_state_out(seq_state_out),
    .lp_clk_gated_out(lp_clk_gated_out), .hp_clk_gated_out(hp_clk_gated_out),
    .hp_pwr_gated_out(hp_pwr_gated_out), .hp_reinit_out(hp_reinit_out),
    .lp_irq_out(lp_irq_out), .radio_on_out(radio_on_out));
  swsg_src_model u_swsg_src_model (
    .mclk_in(mclk_in), .main_evt_out(main_evt), .aon_evt_out(aon_evt),
    .hp_sleep_ipc_out(ipc));
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    @(negedge mclk_in);
  endtask
  task automatic nowake(input logic [11:0] m, input logic [7:0] a);
    u_swsg_src_model.fire(m, a);
    tick(3);
    check(lp_clk_gated_out, 1'b1);
  endtask
  task automatic wake(input logic [11:0] m, input logic [7:0] a, input logic [11:0] src,
                      input logic rein);
    u_swsg_src_model.fire(m, a);
    tick(11);
    check(lp_irq_out, 1'b0);
    tick(1);
    check(lp_irq_out, 1'b1);
    check(hp_reinit_out, rein);
    check(wake_src_out, src);
  endtask
  // bounded wait for the block to fall asleep again
  task automatic resleep(input int n);
    for (int i = 0; i < n && lp_clk_gated_out !== 1'b1; i++) tick(1);
    check(lp_clk_gated_out, 1'b1);
  endtask
  task automatic lock_pulse(input logic [7:0] s, input logic [7:0] c);
    @(posedge mclk_in);
    lock_set_in <= s;
    lock_clr_in <= c;
    @(posedge mclk_in);
    lock_set_in <= 8'h00;
    lock_clr_in <= 8'h00;
  endtask
  task automatic t_radio();
    @(posedge mclk_in);
    assoc_ps_in <= 1'b1;
    tick(2);
    check(radio_on_out, 1'b0);
    @(posedge mclk_in);
    beacon_window_in <= 1'b1;
    tick(2);
    check(radio_on_out, 1'b1);
    @(posedge mclk_in);
    beacon_window_in <= 1'b0;
    tim_pending_in <= 1'b1;
    tick(2);
    check(radio_on_out, 1'b1);
    @(posedge mclk_in);
    assoc_ps_in <= 1'b0;
    tim_pending_in <= 1'b0;
    idle_radio_off_in <= 1'b1;
    tick(2);
    check(radio_on_out, 1'b0);
    @(posedge mclk_in);
    idle_radio_off_in <= 1'b0;
    tick(2);
    check(radio_on_out, 1'b1);
  endtask
  task automatic t_sleep();
    check(wakelock_out, 8'h07);
    check(aon_wake_en_out, 8'h00);
    check(32'(seq_state_out), 32'(SWSG_RUN));
    lock_pulse(8'h00, 8'h04);
    u_swsg_src_model.ipc();
    tick(2);
    check(lp_clk_gated_out, 1'b0);
    check({hp_pwr_gated_out, hp_clk_gated_out}, 2'b01);
    check(wakelock_out, 8'h00);
    tick(1);
    check(lp_clk_gated_out, 1'b1);
    check(32'(seq_state_out), 32'(SWSG_LP_SLEEP));
  endtask
  task automatic t_main();
    for (int i = 0; i < 12; i++) begin
      if (i != 1) begin
        @(posedge mclk_in);
        main_wake_en_in <= 12'h001 << i;
        nowake(12'hFFD & ~(12'h001 << i), 8'h00);
        wake(12'h001 << i, 8'h00, 12'h001 << i, 1'b0);
        check(hp_clk_gated_out, 1'b1);
        resleep(30);
      end
    end
  endtask
  task automatic t_aon();
    @(posedge mclk_in);
    main_wake_en_in <= 12'h000;
    aon_en_wr_in <= 1'b1;
    aon_en_data_in <= 8'hFF;
    @(posedge mclk_in);
    aon_en_wr_in <= 1'b0;
    tick(1);
    check(aon_wake_en_out, 8'hDF);
    nowake(12'h000, 8'hFF);
    @(posedge mclk_in);
    main_wake_en_in <= 12'h002;
    nowake(12'h000, 8'h08);
    @(posedge mclk_in);
    deep_lps_in <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (i != 5) begin
        wake(12'h000, 8'h01 << i, 12'h002, 1'b0);
        resleep(30);
      end
    end
    @(posedge mclk_in);
    deep_sleep_in <= 1'b1;
    main_wake_en_in <= 12'h802;
    nowake(12'h800, 8'h00);
    wake(12'h000, 8'h01, 12'h002, 1'b0);
    resleep(30);
  endtask
  // beacon period of 20 cycles wakes the sleeping low-power core twice
  task automatic t_beacon();
    @(posedge mclk_in);
    wireless_wake_sleep_in <= 1'b1;
    tick(19);
    check(lp_clk_gated_out, 1'b1);
    tick(1);
    check(lp_clk_gated_out, 1'b0);
    check(wake_src_out, 12'h000);
    tick(11);
    check(lp_irq_out, 1'b0);
    tick(1);
    check(lp_irq_out, 1'b1);
    tick(1);
    check(lp_clk_gated_out, 1'b1);
    tick(6);
    check(lp_clk_gated_out, 1'b1);
    tick(1);
    check(lp_clk_gated_out, 1'b0);
    @(posedge mclk_in);
    wireless_wake_sleep_in <= 1'b0;
    resleep(30);
  endtask
  task automatic t_pg();
    @(posedge mclk_in);
    deep_sleep_in <= 1'b0;
    hp_wake_sel_in <= 12'h800;
    hp_pg_sel_in <= 1'b1;
    wake(12'h800, 8'h00, 12'h800, 1'b0);
    tick(1);
    check(hp_clk_gated_out, 1'b0);
    check(wakelock_out, 8'h06);
    lock_pulse(8'h08, 8'h04);
    u_swsg_src_model.ipc();
    tick(6);
    check(hp_pwr_gated_out, 1'b1);
    check(lp_clk_gated_out, 1'b0);
    check(wakelock_out, 8'h08);
    lock_pulse(8'h00, 8'h08);
    resleep(10);
    wake(12'h800, 8'h00, 12'h800, 1'b1);
  endtask
  initial begin
    repeat (20) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    tick(1);
    t_radio();
    t_sleep();
    t_main();
    t_aon();
    t_beacon();
    t_pg();
    end_of_test();
  end
endmodule
